// *** hdl/sbaq_defines.svh ***
// Constants for the receive boost adaptation qualifier.
// Assumes inclusion by the package and by each design module.
`ifndef SBAQ_DEFINES_SVH
`define SBAQ_DEFINES_SVH

`define SBAQ_ATT_W          3
`define SBAQ_BOOST_W        4
`define SBAQ_DFE_W          5
`define SBAQ_CNT_W          8
`define SBAQ_WIN_W          16
`define SBAQ_PER_W          8

`define SBAQ_PATTERN        9'h005
`define SBAQ_ATT_RESET      3'h3
`define SBAQ_BOOST_RESET    4'h7
`define SBAQ_DFE_RESET      5'h0f
`define SBAQ_QUAL_THRESH    8'h10
`define SBAQ_WINDOW_LEN     16'h0400
`define SBAQ_ADAPT_PERIOD   8'h40

`define SBAQ_P23_LEN        23
`define SBAQ_P23_TAP        18
`define SBAQ_P31_LEN        31
`define SBAQ_P31_TAP        28
`define SBAQ_SEED           31'h0000_0001

`endif

// *** hdl/sbaq_pkg.sv ***
// Types shared by the boost adaptation qualifier and its pattern generator.
// Assumes the defines header sits beside it.
`include "sbaq_defines.svh"

package sbaq_pkg;

    typedef enum logic [0:0] {
        SBAQ_PRBS23,
        SBAQ_PRBS31
    } sbaq_prbs_t;

    typedef struct packed {
        logic [30:0] lfsr;
        logic        bit_q;
    } sbaq_gen_state_t;

    typedef struct packed {
        logic [7:0]                   history;
        logic                         phase;
        logic [`SBAQ_CNT_W-1:0]       oddCnt;
        logic [`SBAQ_CNT_W-1:0]       evenCnt;
        logic [`SBAQ_WIN_W-1:0]       winCnt;
        logic [`SBAQ_PER_W-1:0]       perCnt;
        logic [`SBAQ_ATT_W-1:0]       rx_attenuator_setting;
        logic [`SBAQ_BOOST_W-1:0]     boost;
        logic [`SBAQ_DFE_W-1:0]       dfe;
        logic                         unreliable;
        logic                         update;
    } sbaq_state_t;

endpackage

// *** hdl/sbaq_prbs_gen.sv ***
// Self-test pseudo-random bit generator, order 23 or 31.
// Assumes one bit per core_clk and a mode held steady while enabled.
`timescale 1ns/1ps
`include "sbaq_defines.svh"

module sbaq_prbs_gen (
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    input  wire logic               enable,
    input  wire sbaq_pkg::sbaq_prbs_t mode,
    output logic                    prbsBit
);

    sbaq_pkg::sbaq_gen_state_t st;
    sbaq_pkg::sbaq_gen_state_t next_st;
    logic                      feedback;

    // Feedback polynomial per selected order
    always_comb begin
        next_st = st;
        if (mode == sbaq_pkg::SBAQ_PRBS23) begin
            feedback = st.lfsr[`SBAQ_P23_LEN-1] ^ st.lfsr[`SBAQ_P23_TAP-1];
        end else begin
            feedback = st.lfsr[`SBAQ_P31_LEN-1] ^ st.lfsr[`SBAQ_P31_TAP-1];
        end
        if (enable) begin
            next_st.lfsr  = {st.lfsr[29:0], feedback};
            next_st.bit_q = feedback;
        end
    end

    // State register; seed never all zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{lfsr: `SBAQ_SEED, bit_q: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign prbsBit = st.bit_q;

endmodule

// *** hdl/sbaq_adapt.sv ***
// Receive equalization adaptation with boost pattern qualification.
// Assumes one recovered bit per core_clk and comparator hints from the
// analog front end, all synchronous to core_clk.
`timescale 1ns/1ps
`include "sbaq_defines.svh"

module sbaq_adapt #(
    parameter logic [`SBAQ_CNT_W-1:0] QUAL_THRESH  = `SBAQ_QUAL_THRESH,
    parameter logic [`SBAQ_WIN_W-1:0] WINDOW_LEN   = `SBAQ_WINDOW_LEN,
    parameter logic [`SBAQ_PER_W-1:0] ADAPT_PERIOD = `SBAQ_ADAPT_PERIOD
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic                      rxBit,
    input  wire logic                      trainingActive,
    input  wire logic                      adaptEnable,
    input  wire logic [`SBAQ_ATT_W-1:0]    fixedAtt,
    input  wire logic [`SBAQ_BOOST_W-1:0]  fixedBoost,
    input  wire logic [`SBAQ_DFE_W-1:0]    fixedDfe,
    input  wire logic                      attUp,
    input  wire logic                      attDown,
    input  wire logic                      boostUp,
    input  wire logic                      boostDown,
    input  wire logic                      dfeUp,
    input  wire logic                      dfeDown,
    input  wire logic                      bistEnable,
    input  wire sbaq_pkg::sbaq_prbs_t      bistMode,
    output logic                           bistBit,
    output logic [`SBAQ_ATT_W-1:0]         rxAttenuatorSetting,
    output logic [`SBAQ_BOOST_W-1:0]       rxBoostSetting,
    output logic [`SBAQ_DFE_W-1:0]         rxDecisionFeedbackSetting,
    output logic [`SBAQ_CNT_W-1:0]         oddMatchCount,
    output logic [`SBAQ_CNT_W-1:0]         evenMatchCount,
    output logic                           boostUpdated,
    output logic                           boostUnreliable
);

    sbaq_pkg::sbaq_state_t st;
    sbaq_pkg::sbaq_state_t next_st;
    logic                  inBit;
    logic                  match;
    logic                  qualified;
    logic                  periodEnd;

    // Self-test generator, looped into the detector while enabled
    sbaq_prbs_gen u_prbs (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .enable   (bistEnable),
        .mode     (bistMode),
        .prbsBit  (bistBit)
    );

    // Detector input and pattern match on the newest nine bits
    assign inBit     = bistEnable ? bistBit : rxBit;
    assign match     = ({st.history, inBit} == `SBAQ_PATTERN) && !trainingActive;
    assign qualified = (st.oddCnt >= QUAL_THRESH) && (st.evenCnt >= QUAL_THRESH);
    assign periodEnd = (st.perCnt == ADAPT_PERIOD - 1'b1);

    // Next-state logic for detection, windows and settings
    always_comb begin
        next_st         = st;
        next_st.history = {st.history[6:0], inBit};
        next_st.phase   = ~st.phase;
        next_st.update  = 1'b0;
        next_st.perCnt  = periodEnd ? '0 : st.perCnt + 1'b1;

        // Separate alignment counters, saturating
        if (match && st.phase && st.oddCnt != '1) begin
            next_st.oddCnt = st.oddCnt + 1'b1;
        end
        if (match && !st.phase && st.evenCnt != '1) begin
            next_st.evenCnt = st.evenCnt + 1'b1;
        end

        if (!adaptEnable) begin
            // Fixed values override adaptation
            next_st.rx_attenuator_setting        = fixedAtt;
            next_st.boost      = fixedBoost;
            next_st.dfe        = fixedDfe;
            next_st.oddCnt     = '0;
            next_st.evenCnt    = '0;
            next_st.winCnt     = '0;
            next_st.unreliable = 1'b0;
        end else begin
            // Attenuator and feedback track front-end hints
            if (periodEnd) begin
                if (attUp && !attDown && st.rx_attenuator_setting != '1) begin
                    next_st.rx_attenuator_setting = st.rx_attenuator_setting + 1'b1;
                end else if (attDown && !attUp && st.rx_attenuator_setting != '0) begin
                    next_st.rx_attenuator_setting = st.rx_attenuator_setting - 1'b1;
                end
                if (dfeUp && !dfeDown && st.dfe != '1) begin
                    next_st.dfe = st.dfe + 1'b1;
                end else if (dfeDown && !dfeUp && st.dfe != '0) begin
                    next_st.dfe = st.dfe - 1'b1;
                end
            end
            if (qualified) begin
                // Boost moves only once both alignments qualify
                if (boostUp && !boostDown && st.boost != '1) begin
                    next_st.boost = st.boost + 1'b1;
                end else if (boostDown && !boostUp && st.boost != '0) begin
                    next_st.boost = st.boost - 1'b1;
                end
                next_st.update     = 1'b1;
                next_st.unreliable = 1'b0;
                next_st.oddCnt     = '0;
                next_st.evenCnt    = '0;
                next_st.winCnt     = '0;
            end else if (st.winCnt == WINDOW_LEN - 1'b1) begin
                // Window lapsed: boost held, result flagged
                next_st.unreliable = 1'b1;
                next_st.oddCnt     = '0;
                next_st.evenCnt    = '0;
                next_st.winCnt     = '0;
            end else begin
                next_st.winCnt = st.winCnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{history:    8'hff,
                    phase:      1'b0,
                    oddCnt:     '0,
                    evenCnt:    '0,
                    winCnt:     '0,
                    perCnt:     '0,
                    rx_attenuator_setting:        `SBAQ_ATT_RESET,
                    boost:      `SBAQ_BOOST_RESET,
                    dfe:        `SBAQ_DFE_RESET,
                    unreliable: 1'b1,
                    update:     1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Registered outputs
    assign rxAttenuatorSetting       = st.rx_attenuator_setting;
    assign rxBoostSetting            = st.boost;
    assign rxDecisionFeedbackSetting = st.dfe;
    assign oddMatchCount             = st.oddCnt;
    assign evenMatchCount            = st.evenCnt;
    assign boostUpdated              = st.update;
    assign boostUnreliable           = st.unreliable;

endmodule

// *** tb/sbaq_tx_model.sv ***
// Far-end transmitter: qualifying run or coded idle symbols.
// Assumes bits change at the falling edge of core_clk.
`timescale 1ns/1ps
module sbaq_tx_model (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic coded,
    output logic      txBit
);
    logic [8:0] qual;
    logic [9:0] sym;
    // Rotate both frames every cycle so a mode change never glitches
    always @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            qual <= 9'h005;
            sym  <= 10'h0fa;
        end else begin
            qual <= {qual[7:0], qual[8]};
            sym  <= {sym[8:0], sym[9]};
        end
    end
    // Coded idle never holds six zeros in a row
    assign txBit = coded ? sym[9] : qual[8];
endmodule

// *** tb/sbaq_adapt_monitor.sv ***
// Port checker for the boost qualifier.
// Assumes bind into sbaq_adapt, one clock domain.
`timescale 1ns/1ps
`include "sbaq_defines.svh"
module sbaq_adapt_monitor #(
    parameter logic [`SBAQ_CNT_W-1:0] QUAL_THRESH = `SBAQ_QUAL_THRESH
) (
    input wire logic                     core_clk,
    input wire logic                     rst_b,
    input wire logic                     rxBit,
    input wire logic                     trainingActive,
    input wire logic                     adaptEnable,
    input wire logic                     bistEnable,
    input wire logic [`SBAQ_BOOST_W-1:0] fixedBoost,
    input wire logic [`SBAQ_BOOST_W-1:0] rxBoostSetting,
    input wire logic [`SBAQ_CNT_W-1:0]   oddMatchCount,
    input wire logic [`SBAQ_CNT_W-1:0]   evenMatchCount,
    input wire logic                     boostUpdated,
    input wire logic                     boostUnreliable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [8:0]  sh;
    logic [15:0] bh;
    // Recent line bits and recent self-test enables
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh <= 9'h1ff;
            bh <= 16'h0000;
        end else begin
            sh <= {sh[7:0], rxBit};
            bh <= {bh[14:0], bistEnable};
        end
    end
    property p_match;
        (oddMatchCount > $past(oddMatchCount) || evenMatchCount > $past(evenMatchCount))
            && bh == 16'h0000 |-> sh == 9'h005 && !$past(trainingActive);
    endproperty
    a_match: assert property (p_match) else $error("count rose without pattern");
    property p_step;
        oddMatchCount > $past(oddMatchCount) |-> oddMatchCount - $past(oddMatchCount) == 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("odd count jumped");
    property p_split;
        !(oddMatchCount > $past(oddMatchCount) && evenMatchCount > $past(evenMatchCount));
    endproperty
    a_split: assert property (p_split) else $error("both alignments counted");
    property p_cause;
        boostUpdated |-> $past(oddMatchCount) >= QUAL_THRESH
            && $past(evenMatchCount) >= QUAL_THRESH && $past(adaptEnable);
    endproperty
    a_cause: assert property (p_cause) else $error("update below threshold");
    property p_pulse;
        boostUpdated |=> !boostUpdated;
    endproperty
    a_pulse: assert property (p_pulse) else $error("update pulse too long");
    property p_hold;
        adaptEnable && $past(adaptEnable) && !boostUpdated |-> $stable(rxBoostSetting);
    endproperty
    a_hold: assert property (p_hold) else $error("boost moved unqualified");
    property p_unrel;
        boostUpdated |-> !boostUnreliable;
    endproperty
    a_unrel: assert property (p_unrel) else $error("unreliable after update");
    property p_fixed;
        !adaptEnable |=> rxBoostSetting == $past(fixedBoost);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed boost not loaded");
    property p_clear;
        !adaptEnable |=> oddMatchCount == 8'h00 && evenMatchCount == 8'h00 && !boostUpdated;
    endproperty
    a_clear: assert property (p_clear) else $error("adaptation while disabled");
    c_upd: cover property (boostUpdated);
    c_odd: cover property (oddMatchCount > $past(oddMatchCount));
    c_off: cover property (!adaptEnable);
endmodule
bind sbaq_adapt sbaq_adapt_monitor #(.QUAL_THRESH(QUAL_THRESH)) u_mon (.core_clk, .rst_b,
    .rxBit, .trainingActive, .adaptEnable, .bistEnable, .fixedBoost, .rxBoostSetting,
    .oddMatchCount, .evenMatchCount, .boostUpdated, .boostUnreliable);

// *** tb/testbench.sv ***
// Self-checking bench for the boost qualifier with far-end transmitter.
// Assumes shortened threshold, window and period counts.
`timescale 1ns/1ps
`include "sbaq_defines.svh"
module testbench;
    logic core_clk = 1'b0, rst_b = 1'b0, coded = 1'b0, txBit, trainingActive = 1'b0;
    logic adaptEnable = 1'b1, bistEnable = 1'b0, bistBit, boostUpdated, boostUnreliable;
    logic [5:0] hint = 6'h00;
    logic [2:0] rx_attenuator_setting;
    logic [3:0] boost, b;
    logic [3:0] fixedBoostVal = 4'h9;
    logic [4:0] dfe;
    logic [7:0] oddCnt, evenCnt;
    logic sawOdd, sawEven, sawUpd;
    sbaq_pkg::sbaq_prbs_t bistMode = sbaq_pkg::SBAQ_PRBS23;
    int n_errors = 0, cmp_count = 0;
    sbaq_tx_model far (.core_clk, .rst_b, .coded, .txBit);
    sbaq_adapt #(.QUAL_THRESH(8'h04), .WINDOW_LEN(16'h0100), .ADAPT_PERIOD(8'h08)) dut (
        .core_clk, .rst_b, .rxBit(txBit), .trainingActive, .adaptEnable,
        .fixedAtt(3'h5), .fixedBoost(fixedBoostVal), .fixedDfe(5'h11), .attUp(hint[5]),
        .attDown(hint[4]), .boostUp(hint[3]), .boostDown(hint[2]), .dfeUp(hint[1]),
        .dfeDown(hint[0]), .bistEnable, .bistMode, .bistBit, .rxAttenuatorSetting(rx_attenuator_setting),
        .rxBoostSetting(boost), .rxDecisionFeedbackSetting(dfe), .oddMatchCount(oddCnt),
        .evenMatchCount(evenCnt), .boostUpdated, .boostUnreliable);
    // Clock and sticky activity flags
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        sawOdd  |= (oddCnt !== 8'h00);
        sawEven |= (evenCnt !== 8'h00);
        sawUpd  |= (boostUpdated === 1'b1);
    end
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Disable for a cycle to clear counters, then clear flags
    task automatic restart;
        adaptEnable = 1'b0;
        run(1);
        adaptEnable = 1'b1;
        run(1);
        {sawOdd, sawEven, sawUpd} = 3'b000;
    endtask
    task automatic t_fixed;
        adaptEnable = 1'b0;
        hint = 6'b101010;
        coded = 1'b0;
        run(20);
        chk(boost === 4'h9, "fixed boost first value");
        fixedBoostVal = 4'h2;
        run(2);
        chk(rx_attenuator_setting === 3'h5 && boost === 4'h2 && dfe === 5'h11, "fixed values");
        chk(oddCnt === 8'h00 && !boostUpdated && boostUnreliable === 1'b0, "disabled");
    endtask
    task automatic t_qualify;
        int i;
        hint = 6'b101001;
        restart();
        for (i = 0; i < 600 && boostUpdated !== 1'b1; i++) run(1);
        chk(sawOdd && sawEven && boostUpdated === 1'b1, "no qualified update");
        chk(boost === 4'h3 && boostUnreliable === 1'b0, "boost step");
        chk(rx_attenuator_setting > 3'h5 && dfe < 5'h11, "att and dfe steps");
    endtask
    task automatic t_coded;
        coded = 1'b1;
        restart();
        b = boost;
        run(600);
        chk(!sawOdd && !sawEven && !sawUpd && boost === b, "coded traffic qualified");
        chk(boostUnreliable === 1'b1, "unreliable not flagged");
    endtask
    task automatic t_training;
        coded = 1'b0;
        trainingActive = 1'b1;
        restart();
        run(300);
        chk(!sawOdd && !sawEven && !sawUpd, "training counted");
        trainingActive = 1'b0;
    endtask
    task automatic t_bist;
        coded = 1'b1;
        for (int m = 0; m < 2; m++) begin
            bistMode = sbaq_pkg::sbaq_prbs_t'(m);
            run(1);
            bistEnable = 1'b1;
            restart();
            run(4000);
            chk(sawOdd && sawEven, "self-test pattern did not qualify");
            bistEnable = 1'b0;
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        run(6);
        chk(rx_attenuator_setting === `SBAQ_ATT_RESET && boost === `SBAQ_BOOST_RESET, "reset att/boost");
        chk(dfe === `SBAQ_DFE_RESET && boostUnreliable === 1'b1, "reset dfe/flag");
        rst_b = 1'b1;
        t_fixed();
        t_qualify();
        t_coded();
        t_training();
        t_bist();
        tally_and_finish();
    end
    // Watchdog
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule
